// *** core/php_port.sv ***
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE1: Pulse mode starts a transfer without checking the flag for Ready.
// RULE2: Next transfer may start once the strobe clears, whatever the flag level.
// RULE3: Output: direction low, data out, wait control delay, then set strobe.
// RULE4: Flag Ready-to-Busy edge while strobe set clears the strobe.
// RULE5: Busy-pulse peripheral reads output data before driving flag Busy.
// RULE6: Input: direction high, then set strobe without checking the flag; the code raises both on the same clock edge.
// RULE7: Peripheral settles input data before driving flag Busy.
// RULE8: Input data may be taken any time after the strobe has cleared.
// RULE9: Ready-pulse peripheral raises Ready, then returns Busy to clear strobe.
// RULE10: Output data stays stable while the strobe is set.
// RULE11: Ready-pulse input: data and Ready in either order, data settles first.
// RULE12: Interface reset drives peripheral reset low at least 15 microseconds.
// RULE13: Interface reset forces the strobe to Clear.
// RULE14: Reset zeroes output data only when the clear option is fitted.
// RULE15: Reset clears the interrupt enable bit.
// RULE16: Reset keeps aux controls and direction line unchanged.
// RULE17: Software reset request does the same as system reset; here it keeps aux, direction and delay, which system reset reloads.
// RULE18: Direction line high for input, low for output, fixed polarity.
// RULE19: Strobe and flag polarities each selectable by configuration.
// RULE20: Input capture edge selectable: Ready-to-Busy or Busy-to-Ready.
// RULE21: Control delay is a programmable cycle count, nonzero default.
module php_port #(
  parameter int unsigned PRESET_LEN = php_pkg::PRESET_CYCLES,
  parameter int unsigned DATA_W     = 16
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              dout_clear_fit_i,
  input  wire logic              hsel_i,
  input  wire logic [31:0]       haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic      [31:0]       hrdata_o,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  input  wire logic              peripheral_flag_i,
  input  wire logic [DATA_W-1:0] din_i,
  output logic                   peripheral_control_strobe_o,
  output logic                   dir_o,
  output logic      [DATA_W-1:0] dout_o,
  output logic                   preset_n_o,
  output logic                   aux_control_a_o,
  output logic                   aux_control_b_o,
  output logic                   irq_en_o
);
  import php_pkg::*;

  initial begin
    if (DATA_W < 1 || DATA_W > 32) $error("DATA_W must be 1..32");
    if (PRESET_LEN < 1 || PRESET_LEN > 65535) $error("PRESET_LEN must be 1..65535");
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave: address phase capture, zero-wait data phase
  // ----------------------------------------------------------------
  logic             wr_pend_q;
  logic             rd_pend_q;
  logic [7:0]       addr_q;
  logic             addr_ok;

  assign addr_ok = hsel_i && hready_i && htrans_i[1];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else begin
      if (hready_i) begin
        wr_pend_q <= addr_ok && hwrite_i;
        rd_pend_q <= addr_ok && !hwrite_i;
      end
      if (addr_ok) begin
        addr_q <= haddr_i[7:0];
      end
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  logic wr_ctrl;
  logic wr_dout;
  logic wr_delay;
  logic wr_cmd;
  assign wr_ctrl  = wr_pend_q && (addr_q == CTRL_OFF);
  assign wr_dout  = wr_pend_q && (addr_q == DOUT_OFF);
  assign wr_delay = wr_pend_q && (addr_q == DELAY_OFF);
  assign wr_cmd   = wr_pend_q && (addr_q == CMD_OFF);

  // ----------------------------------------------------------------
  // Interface reset: system reset or software request
  // ----------------------------------------------------------------
  logic        if_rst;
  logic [15:0] preset_cnt_q;

  assign if_rst = wr_cmd && hwdata_i[CMD_SW_RESET]; // see RULE17

  // Pulse is stretched by a counter so it spans at least the full width
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      preset_cnt_q <= 16'(PRESET_LEN); // see RULE12
    end else if (if_rst) begin
      preset_cnt_q <= 16'(PRESET_LEN); // see RULE12
    end else if (preset_cnt_q != 16'h0000) begin
      preset_cnt_q <= preset_cnt_q - 16'h0001;
    end
  end

  assign preset_n_o = (preset_cnt_q == 16'h0000);

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  logic [CTRL_WIDTH-1:0] ctrl_q;
  logic [15:0]           delay_q;

  // Aux and direction bits survive an interface reset; only power-on resets them
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (if_rst) begin
      ctrl_q[CTRL_IRQ_EN] <= 1'b0; // see RULE15 RULE16
    end else if (wr_ctrl) begin
      ctrl_q <= hwdata_i[CTRL_WIDTH-1:0]; // see RULE19 RULE20
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      delay_q <= DELAY_RESET; // see RULE21
    end else if (wr_delay) begin
      delay_q <= (hwdata_i[15:0] == 16'h0000) ? 16'h0001 : hwdata_i[15:0]; // see RULE21
    end
  end

  assign aux_control_a_o = ctrl_q[CTRL_AUX_A];
  assign aux_control_b_o = ctrl_q[CTRL_AUX_B];
  assign irq_en_o        = ctrl_q[CTRL_IRQ_EN];

  // ----------------------------------------------------------------
  // Flag edge detection (flag polarity applied first)
  // ----------------------------------------------------------------
  logic flag_busy;
  logic flag_busy_q;
  logic rdy_to_busy;
  logic busy_to_rdy;

  assign flag_busy = peripheral_flag_i ^ ctrl_q[CTRL_FLAG_INV]; // see RULE19

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flag_busy_q <= 1'b0;
    end else begin
      flag_busy_q <= flag_busy;
    end
  end

  assign rdy_to_busy = flag_busy && !flag_busy_q;
  assign busy_to_rdy = !flag_busy && flag_busy_q;

  // ----------------------------------------------------------------
  // Handshake sequencer
  // ----------------------------------------------------------------
  php_state_t  state_q;
  logic        strobe_q;
  logic        dir_q;
  logic [15:0] dly_cnt_q;
  logic        start_out;
  logic        start_in;

  // Flag is never consulted before a start
  assign start_out = wr_cmd && hwdata_i[CMD_START_OUT] && !if_rst; // see RULE1
  assign start_in  = wr_cmd && hwdata_i[CMD_START_IN] && !if_rst && !hwdata_i[CMD_START_OUT]; // see RULE6

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q   <= ST_IDLE;
      strobe_q  <= 1'b0;
      dly_cnt_q <= 16'h0000;
    end else if (if_rst) begin
      state_q  <= ST_IDLE;
      strobe_q <= 1'b0; // see RULE13
    end else begin
      unique case (state_q)
        ST_IDLE, ST_DONE: begin
          // Idle once strobe is clear, so a new start is taken at once
          if (start_out) begin // see RULE2
            state_q   <= ST_SETUP;
            dly_cnt_q <= delay_q; // see RULE3
          end else if (start_in) begin
            state_q  <= ST_ARMED;
            strobe_q <= 1'b1; // see RULE6
          end
        end
        ST_SETUP: begin
          if (dly_cnt_q <= 16'h0001) begin
            state_q  <= ST_ARMED;
            strobe_q <= 1'b1; // see RULE3
          end else begin
            dly_cnt_q <= dly_cnt_q - 16'h0001;
          end
        end
        ST_ARMED: begin
          if (rdy_to_busy) begin
            state_q  <= ST_DONE;
            strobe_q <= 1'b0; // see RULE4 RULE9
          end
        end
        default: begin
          state_q  <= ST_IDLE;
          strobe_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dir_q <= 1'b0;
    end else if (start_out && !busy_xfer) begin
      dir_q <= 1'b0; // see RULE18
    end else if (start_in && !busy_xfer) begin
      dir_q <= 1'b1; // see RULE18
    end else if (wr_ctrl && state_q != ST_ARMED && state_q != ST_SETUP) begin
      dir_q <= hwdata_i[CTRL_DIR];
    end
  end

  assign dir_o = dir_q; // see RULE16
  assign peripheral_control_strobe_o = strobe_q ^ ctrl_q[CTRL_STROBE_INV]; // see RULE19

  // ----------------------------------------------------------------
  // Data out: frozen while a transfer is in flight
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] dout_q;
  logic              busy_xfer;
  assign busy_xfer = (state_q == ST_SETUP) || (state_q == ST_ARMED);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dout_q <= '0;
    end else if (if_rst) begin
      if (dout_clear_fit_i) begin
        dout_q <= '0; // see RULE14
      end
    end else if (wr_dout && !busy_xfer) begin
      dout_q <= hwdata_i[DATA_W-1:0]; // see RULE10
    end
  end

  assign dout_o = dout_q;

  // ----------------------------------------------------------------
  // Data in: captured on the selected flag edge of an input transfer
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] din_q;
  logic              din_new_q;
  logic              cap_edge;
  logic              in_xfer;
  logic              rd_din;

  assign in_xfer  = dir_q && (state_q == ST_ARMED || state_q == ST_DONE);
  assign cap_edge = ctrl_q[CTRL_BUSY_CAP] ? rdy_to_busy : busy_to_rdy; // see RULE20
  assign rd_din   = rd_pend_q && (addr_q == DIN_OFF);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      din_q     <= '0;
      din_new_q <= 1'b0;
    end else begin
      if (in_xfer && cap_edge) begin
        din_q     <= din_i; // see RULE8
        din_new_q <= 1'b1;
      end else if (rd_din) begin
        din_new_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    hrdata_o = 32'h0000_0000;
    if (rd_pend_q) begin
      unique case (addr_q)
        CTRL_OFF: begin
          hrdata_o = {25'h0, dir_q, ctrl_q[CTRL_DIR-1:0]};
        end
        STATUS_OFF: begin
          hrdata_o = {27'h0, (preset_cnt_q != 16'h0000), !busy_xfer, din_new_q,
                      flag_busy, strobe_q};
        end
        DOUT_OFF:  hrdata_o = 32'(dout_q);
        DIN_OFF:   hrdata_o = 32'(din_q);
        DELAY_OFF: hrdata_o = {16'h0, delay_q};
        default:   hrdata_o = 32'h0000_0000;
      endcase
    end
  end

endmodule : php_port

`default_nettype wire

// *** core/php_pkg.sv ***
package php_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] DOUT_OFF   = 8'h08;
  localparam logic [7:0] DIN_OFF    = 8'h0c;
  localparam logic [7:0] DELAY_OFF  = 8'h10;
  localparam logic [7:0] CMD_OFF    = 8'h14;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_STROBE_INV = 0;
  localparam int CTRL_FLAG_INV   = 1;
  localparam int CTRL_BUSY_CAP   = 2;
  localparam int CTRL_IRQ_EN     = 3;
  localparam int CTRL_AUX_A      = 4;
  localparam int CTRL_AUX_B      = 5;
  localparam int CTRL_DIR        = 6;
  localparam int CTRL_WIDTH      = 7;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 7'h04;

  // ----------------------------------------------------------------
  // Command register fields
  // ----------------------------------------------------------------
  localparam int CMD_START_OUT = 0;
  localparam int CMD_START_IN  = 1;
  localparam int CMD_SW_RESET  = 2;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int STAT_STROBE   = 0;
  localparam int STAT_FLAG     = 1;
  localparam int STAT_DIN_NEW  = 2;
  localparam int STAT_IDLE     = 3;
  localparam int STAT_RST_BUSY = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ            = 25_000_000;
  localparam int PRESET_US         = 15;
  localparam int PRESET_CYCLES     = (PRESET_US * (CLK_HZ / 1_000_000));
  localparam logic [15:0] DELAY_RESET = 16'h0004;

  // ----------------------------------------------------------------
  // AHB encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_ARMED = 4'b0100,
    ST_DONE  = 4'b1000
  } php_state_t;

endpackage : php_pkg

// *** verification/php_port_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module php_port_monitor #(
  parameter int unsigned PRESET_LEN = 8,
  parameter int unsigned DATA_W     = 16
) (
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  input wire logic              dout_clear_fit_i,
  input wire logic              hreadyout_o,
  input wire logic              hresp_o,
  input wire logic              peripheral_flag_i,
  input wire logic              peripheral_control_strobe_o,
  input wire logic              dir_o,
  input wire logic [DATA_W-1:0] dout_o,
  input wire logic              preset_n_o,
  input wire logic              aux_control_a_o,
  input wire logic              aux_control_b_o,
  input wire logic              irq_en_o
);
  logic [15:0] low_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Counts low cycles; a short pulse may not reset a slow peripheral
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || preset_n_o) begin
      low_q <= 16'h0000;
    end else begin
      low_q <= low_q + 16'h0001;
    end
  end
  sequence s_clear; ##[1:3] !peripheral_control_strobe_o; endsequence
  sequence s_out_set; !dir_o && $rose(peripheral_control_strobe_o); endsequence
  property p_bus_okay; hreadyout_o && !hresp_o; endproperty
  property p_preset_len; $rose(preset_n_o) |-> low_q >= PRESET_LEN - 1; endproperty
  property p_flag_clr; peripheral_control_strobe_o && $rose(peripheral_flag_i) |-> s_clear;
  endproperty
  property p_strb_cause; $fell(peripheral_control_strobe_o) |-> peripheral_flag_i || !preset_n_o;
  endproperty
  property p_dout_hold; peripheral_control_strobe_o ##1 peripheral_control_strobe_o
    |-> $stable(dout_o); endproperty
  property p_out_order; s_out_set |-> !$past(dir_o, 2) && $past(dout_o, 2) == dout_o;
  endproperty
  property p_rst_strb; $fell(preset_n_o) |-> ##[0:1] !peripheral_control_strobe_o; endproperty
  property p_rst_irq; $fell(preset_n_o) |-> ##[0:1] !irq_en_o; endproperty
  property p_rst_keep; $fell(preset_n_o)
    |-> $stable(dir_o) && $stable(aux_control_a_o) && $stable(aux_control_b_o); endproperty
  property p_dout_clr; $fell(preset_n_o) && dout_clear_fit_i |-> ##[0:1] dout_o == '0;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus response not okay");
  a_preset_len: assert property (p_preset_len) else $error("reset pulse short");
  a_flag_clr: assert property (p_flag_clr) else $error("strobe not cleared");
  a_strb_cause: assert property (p_strb_cause) else $error("strobe cleared early");
  a_dout_hold: assert property (p_dout_hold) else $error("data moved");
  a_out_order: assert property (p_out_order) else $error("strobe before setup");
  a_rst_strb: assert property (p_rst_strb) else $error("strobe kept");
  a_rst_irq: assert property (p_rst_irq) else $error("irq enable kept");
  a_rst_keep: assert property (p_rst_keep) else $error("line changed");
  a_dout_clr: assert property (p_dout_clr) else $error("data not cleared");
endmodule : php_port_monitor
bind php_port php_port_monitor #(.PRESET_LEN(PRESET_LEN), .DATA_W(DATA_W)) u_mon (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .dout_clear_fit_i(dout_clear_fit_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .peripheral_flag_i(peripheral_flag_i),
  .peripheral_control_strobe_o(peripheral_control_strobe_o), .dir_o(dir_o),
  .dout_o(dout_o), .preset_n_o(preset_n_o), .aux_control_a_o(aux_control_a_o),
  .aux_control_b_o(aux_control_b_o), .irq_en_o(irq_en_o));
`default_nettype wire

// *** verification/php_periph_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module php_periph_model (
  input  wire logic        clk_i,
  input  wire logic        strobe_i,
  input  wire logic        dir_i,
  input  wire logic [15:0] dout_i,
  input  wire logic        rp_i,
  input  wire logic [15:0] dv_i,
  output logic             flag_o,
  output logic      [15:0] din_o,
  output logic      [15:0] cap_o
);
  // Ready-pulse units idle Busy, busy-pulse units idle Ready
  initial begin
    flag_o = 1'b0;
    din_o  = 16'h0000;
    cap_o  = 16'h0000;
    forever begin
      @(posedge clk_i);
      if (strobe_i !== 1'b1) begin
        flag_o <= rp_i;
      end else begin
        cap_o <= dout_i;
        if (dir_i === 1'b1) din_o <= dv_i;
        repeat (rp_i ? 5 : 1) @(posedge clk_i);
        flag_o <= 1'b0;
        @(posedge clk_i);
        flag_o <= 1'b1;
        repeat (12) @(posedge clk_i);
        flag_o <= rp_i;
        @(posedge clk_i);
        din_o <= ~din_o;
      end
    end
  end
endmodule : php_periph_model
`default_nettype wire

// *** verification/php_port_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module php_port_test;
  import php_pkg::*;
  localparam int unsigned PL = 8;
  logic        clk_i, rst_n_i = 1'b0, fit = 1'b0, hsel = 1'b0, hwrite = 1'b0, rp = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0]  htrans = 2'h0;
  logic [15:0] dv = 16'h0000;
  wire logic   strobe, dir, flag, pre_n, aux_a, aux_b, irq, hready, hresp;
  wire logic [31:0] hrdata;
  wire logic [15:0] dout, din, cap;
  int          n_mismatch = 0, compares = 0, i, j, k;
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  php_port #(.PRESET_LEN(PL)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .dout_clear_fit_i(fit),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(HSIZE_WORD),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .peripheral_flag_i(flag), .din_i(din), .peripheral_control_strobe_o(strobe),
    .dir_o(dir), .dout_o(dout), .preset_n_o(pre_n), .aux_control_a_o(aux_a),
    .aux_control_b_o(aux_b), .irq_en_o(irq));
  php_periph_model u_per (.clk_i(clk_i), .strobe_i(strobe), .dir_i(dir), .dout_i(dout),
    .rp_i(rp), .dv_i(dv), .flag_o(flag), .din_o(din), .cap_o(cap));
  task automatic summarize;
    if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wrdy;
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 50) begin n_mismatch++; summarize(); end
    end while (hready !== 1'b1);
  endtask : wrdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel <= 1'b1; htrans <= HTRANS_NONSEQ; hwrite <= w; haddr <= {24'h0, a};
    wrdy();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wrdy();
    rd = hrdata;
  endtask : bus
  // Waits on the strobe or the reset pulse, n = cycles taken
  task automatic ws(input logic p, input logic l, output int n);
    n = 0;
    while ((p ? pre_n : strobe) !== l) begin
      @(posedge clk_i); #1;
      n++;
      if (n > 200) begin n_mismatch++; summarize(); end
    end
  endtask : ws
  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    ws(1'b1, 1'b1, k); chk("preset_len", 32'(k >= PL - 1), 32'h1);
    bus(1'b0, CTRL_OFF, 32'h0); chk("ctrl_rst", rd, 32'(CTRL_RESET));
    bus(1'b0, DELAY_OFF, 32'h0); chk("delay_rst", rd, 32'(DELAY_RESET));
    bus(1'b0, 8'h18, 32'h0); chk("unmapped", rd, 32'h0);
    bus(1'b1, DELAY_OFF, 32'h0); bus(1'b0, DELAY_OFF, 32'h0);
    chk("delay_min", rd, 32'h1);
    bus(1'b1, DELAY_OFF, 32'h0000000a);
    for (i = 0; i < 2; i++) begin
      rp <= i[0];
      bus(1'b1, DOUT_OFF, 32'h0000a5c3 + i);
      bus(1'b1, CMD_OFF, 32'h1); ws(1'b0, 1'b1, k);
      chk("out_delay", 32'(k >= 9), 32'h1);
      chk("dir_out", 32'(dir), 32'h0);
      ws(1'b0, 1'b0, k); chk("cap", 32'(cap), 32'h0000a5c3 + i);
      for (j = 0; j < 2; j++) begin
        // Let the peripheral finish its trailing flag edge so it is not taken as new data
        repeat (16) @(posedge clk_i);
        bus(1'b1, CTRL_OFF, j ? 32'h0 : 32'h4);
        dv <= 16'hbee0 + 16'(2 * i + j);
        bus(1'b1, CMD_OFF, 32'h2); ws(1'b0, 1'b1, k);
        chk("dir_in", 32'(dir), 32'h1);
        ws(1'b0, 1'b0, k);
        for (k = 0; k < 40; k++) begin
          bus(1'b0, STATUS_OFF, 32'h0);
          if (rd[STAT_DIN_NEW] === 1'b1) break;
        end
        if (k >= 40) begin n_mismatch++; summarize(); end
        bus(1'b0, DIN_OFF, 32'h0); chk("din", rd, 32'h0000bee0 + 2 * i + j);
      end
    end
    bus(1'b1, CTRL_OFF, 32'h0000007c); bus(1'b1, DOUT_OFF, 32'h00001111);
    chk("irq_on", 32'(irq), 32'h1);
    for (i = 0; i < 2; i++) begin
      fit <= i[0];
      bus(1'b1, CMD_OFF, 32'h4); @(posedge clk_i); #1;
      ws(1'b1, 1'b1, k); chk("sw_len", 32'(k >= PL - 2), 32'h1);
      chk("keep", {26'h0, strobe, irq, aux_a, aux_b, dir, 1'b0}, 32'h0e);
      chk("dout", 32'(dout), i ? 32'h0 : 32'h1111);
    end
    bus(1'b0, CTRL_OFF, 32'h0); chk("ctrl_sw", rd, 32'h00000074);
    summarize();
  end
endmodule : php_port_test
`default_nettype wire
